/* pci_tgt_pkg.sv */
// Shared constants, field layouts and carrier types of the PCI target image decoder.
package pci_tgt_pkg;

	// ==================================================================
	// Image count and APB register map (byte addresses)
	localparam int IMAGE_COUNT = 2;
	localparam int APB_ADDR_W = 12;
	localparam logic [11:0] OFS_MISC2 = 12'h020;
	localparam logic [11:0] OFS_REGWIN = 12'h024;
	localparam logic [6:0] IMG_AREA_HI = 7'h00;
	localparam int IMG_SEL_BIT = 4;
	localparam logic [1:0] WORD_CTRL = 2'h0;
	localparam logic [1:0] WORD_LADDR = 2'h1;
	localparam logic [1:0] WORD_PBASE = 2'h2;

	// ==================================================================
	// Field positions
	localparam int CTRL_EN_BIT = 31;
	localparam int CTRL_SPACE_BIT = 24;
	localparam int CTRL_BS_LSB = 20;
	localparam int CTRL_TC_LSB = 16;
	localparam int LADDR_BASE_LSB = 16;
	localparam int LADDR_XLAT_LSB = 0;
	localparam int PBASE_BA_LSB = 16;
	localparam int PBASE_SPACE_BIT = 0;
	localparam int MISC2_HOLD_BIT = 0;
	localparam int REGWIN_LSB = 12;
	localparam int EE_IMG0_EN_BIT = 5;
	localparam int EE_IMG1_EN_BIT = 7;

	// ==================================================================
	// PCI commands as driven on C/BE[3:0] during the address phase
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'ha;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;
	localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
	localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
	localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;
	localparam logic [1:0] CFG_TYPE0 = 2'h0;

	// ==================================================================
	// Reset values
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [15:0] MASK_ALL = 16'hffff;
	localparam logic [19:0] REGWIN_RESET = 20'h0_0000;

	// Block-size code to the number of low base bits that are not compared
	function automatic logic [3:0] bs_ignored(input logic [3:0] code);
		logic [3:0] ign;
		ign = code;
		if (code == 4'hf) begin
			ign = 4'hb; // Code all ones means 128 Mbyte
		end else if (code >= 4'hb) begin
			ign = code + 4'h1;
		end
		return ign;
	endfunction

	// Mask of the compared upper address lines AD[31:16]
	function automatic logic [15:0] bs_mask(input logic [3:0] code);
		return MASK_ALL << bs_ignored(code);
	endfunction

	// ==================================================================
	// Carrier types
	typedef struct packed {
		logic en;
		logic space;
		logic [3:0] bs;
		logic [3:0] tc;
		logic [15:0] base;
		logic [15:0] xlat;
	} img_t;

	typedef struct packed {
		logic frame_n;
		logic idsel;
		logic [31:0] ad;
		logic [3:0] cbe_n;
	} pci_addr_t;

	typedef struct packed {
		logic devsel_n;
		logic stop_n;
		logic drive_oe_n;
	} pci_resp_t;

	typedef struct packed {
		logic valid;
		logic image;
		logic write;
		logic io;
		logic [3:0] byte_en;
		logic [31:0] addr;
		logic [3:0] tc;
	} local_req_t;

	typedef struct packed {
		logic [7:0] byte7;
		logic [7:0] byte8;
		logic [1:0][3:0] bs;
		logic [1:0] space;
	} ee_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CLAIMED = 3'b010,
		ST_IGNORED = 3'b100
	} dec_state_t;

endpackage

/* pci_target_image_decoder.sv */
// Address-phase decoder, translator and image registers of the PCI target channel.
// ==================================================================
// Overview of operation
// - Claim a PCI cycle when its address hits an enabled image range, the register window or Type 0 config.
// - Two equal, independent images, each with own decode and translation fields.
// - Each image has an enable; with both off no I/O cycle and only register-window memory cycles are claimed.
// - Per-image space bit picks PCI memory space or PCI I/O space.
// - Compare only the upper address lines that the block size selects.
// - On an image hit assert device select within two clocks of frame.
// - Respond to I/O, memory and Type 0 configuration reads and writes.
// - Read multiple and read line act as read; write and invalidate as write.
// - Local address takes upper bits from translation base, lower from PCI.
// - Local cycle kind follows the hit image, command and byte enables.
// - Drive the local transaction code from the hit image's code field.
// - Base register enabled by EEPROM byte 7 bit 5, image 1 byte 8 bit 7.
// - While access hold is set, retry every PCI access; cleared, allow them.
// - EEPROM mode loads block size and space read-only; space readable twice.
// - Without EEPROM, block size and space are written only via control reg.
// - EEPROM mode: base written only via PCI base reg, readable from both.
// - Writable base bits follow block size, so sizing reads back the mask.
// - Without EEPROM, base is set only via local address reg, no sizing.
// - Accept Type 0 config, ignore Type 1, never forward config locally.
`timescale 1ns/10ps

module pci_target_image_decoder
	import pci_tgt_pkg::*;
#(
	parameter int IMAGES = IMAGE_COUNT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [APB_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pci_addr_t pci_in,
	output pci_resp_t pci_resp,
	input wire ee_cfg_t ee_cfg,
	input wire logic hold_strap,
	output local_req_t local_req
);

	// ==================================================================
	// Elaboration check: EEPROM enables exist for exactly two images
	if (IMAGES != IMAGE_COUNT) begin : g_bad_images
		$error("pci_target_image_decoder supports exactly two images");
	end

	// ==================================================================
	// State of the whole block in one record
	typedef struct packed {
		img_t [1:0] img;
		logic [1:0] ee_mode;
		logic hold;
		logic booted;
		logic [19:0] reg_win;
		dec_state_t state;
		logic pending;
		pci_resp_t resp;
		local_req_t req;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} st_t;

	localparam st_t ST_RESET = '{
		img: '0,
		ee_mode: 2'h0,
		hold: 1'b1,
		booted: 1'b0,
		reg_win: REGWIN_RESET,
		state: ST_IDLE,
		pending: 1'b0,
		resp: '{devsel_n: 1'b1, stop_n: 1'b1, drive_oe_n: 1'b1},
		req: '0,
		pready: 1'b0,
		pslverr: 1'b0,
		prdata: ZERO_WORD
	};

	st_t r;
	st_t nxt;

	// APB decode results
	logic reg_mapped;
	logic is_misc;
	logic is_regwin;
	logic is_img;
	logic dec_idx;
	logic [1:0] dec_word;

	// PCI address-phase decode results
	logic [3:0] cmd;
	logic is_io;
	logic is_mem;
	logic is_cfg0;
	logic is_write;
	logic reg_hit;
	logic [1:0] img_hit;
	logic [1:0] ee_en;

	// ==================================================================
	// APB address decode; the image words sit in one block, image index in one bit
	always_comb begin
		is_misc = 1'b0;
		is_regwin = 1'b0;
		is_img = 1'b0;
		dec_idx = paddr[IMG_SEL_BIT];
		dec_word = paddr[3:2];
		if (paddr[1:0] != 2'h0) begin
			is_img = 1'b0; // Unaligned byte address is unmapped
		end else if (paddr == OFS_MISC2) begin
			is_misc = 1'b1;
		end else if (paddr == OFS_REGWIN) begin
			is_regwin = 1'b1;
		end else if (paddr[11:5] == IMG_AREA_HI && paddr[3:2] <= WORD_PBASE) begin
			is_img = 1'b1;
		end
		reg_mapped = is_misc | is_regwin | is_img;
	end

	// ==================================================================
	// PCI command classes; aliases fold onto plain read and write
	always_comb begin
		cmd = pci_in.cbe_n;
		is_io = (cmd == CMD_IO_RD) || (cmd == CMD_IO_WR);
		is_mem = (cmd == CMD_MEM_RD) || (cmd == CMD_MEM_WR) ||
			(cmd == CMD_MEM_RD_MULT) || (cmd == CMD_MEM_RD_LINE) ||
			(cmd == CMD_MEM_WR_INV);
		// Type 1 carries 01 in AD[1:0] and so never qualifies here
		is_cfg0 = ((cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR)) &&
			pci_in.idsel && (pci_in.ad[1:0] == CFG_TYPE0);
		is_write = (cmd == CMD_IO_WR) || (cmd == CMD_MEM_WR) ||
			(cmd == CMD_MEM_WR_INV) || (cmd == CMD_CFG_WR);
		// Register window is checked first so a careless overlap still lands there
		reg_hit = is_mem && (pci_in.ad[31:12] == r.reg_win);
		for (int i = 0; i < IMAGE_COUNT; i++) begin
			// Each image compares only its own fields
			img_hit[i] = r.img[i].en &&
				((is_mem && !r.img[i].space) || (is_io && r.img[i].space)) &&
				(((pci_in.ad[31:16] ^ r.img[i].base) & bs_mask(r.img[i].bs)) ==
				16'h0000);
		end
		ee_en = {ee_cfg.byte8[EE_IMG1_EN_BIT], ee_cfg.byte7[EE_IMG0_EN_BIT]};
	end

	// ==================================================================
	// Next-state logic for registers, APB answer and PCI claim
	always_comb begin
		logic [31:0] rd;
		logic hit_sel;
		logic [15:0] m;
		rd = ZERO_WORD;
		hit_sel = 1'b0;
		m = MASK_ALL;
		nxt = r;
		nxt.req.valid = 1'b0;
		nxt.pready = 1'b0;
		nxt.pslverr = 1'b0;

		// Straps and EEPROM fields are taken once, on the first edge after reset
		if (!r.booted) begin
			nxt.booted = 1'b1;
			nxt.hold = hold_strap;
			nxt.ee_mode = ee_en;
			for (int i = 0; i < IMAGE_COUNT; i++) begin
				if (ee_en[i]) begin
					nxt.img[i].bs = ee_cfg.bs[i];
					nxt.img[i].space = ee_cfg.space[i];
				end
			end
		end

		// Setup phase: capture read data so the access phase answers from flops
		if (psel && !penable) begin
			m = bs_mask(r.img[dec_idx].bs);
			if (is_misc) begin
				rd[MISC2_HOLD_BIT] = r.hold;
			end else if (is_regwin) begin
				rd[31:REGWIN_LSB] = r.reg_win;
			end else if (is_img && dec_word == WORD_CTRL) begin
				rd[CTRL_EN_BIT] = r.img[dec_idx].en;
				rd[CTRL_SPACE_BIT] = r.img[dec_idx].space;
				rd[CTRL_BS_LSB +: 4] = r.img[dec_idx].bs;
				rd[CTRL_TC_LSB +: 4] = r.img[dec_idx].tc;
			end else if (is_img && dec_word == WORD_LADDR) begin
				rd[LADDR_BASE_LSB +: 16] = r.img[dec_idx].base;
				rd[LADDR_XLAT_LSB +: 16] = r.img[dec_idx].xlat;
			end else if (is_img && r.ee_mode[dec_idx]) begin
				// A disabled base register reads as zero
				rd[PBASE_BA_LSB +: 16] = r.img[dec_idx].base & m;
				rd[PBASE_SPACE_BIT] = r.img[dec_idx].space;
			end
			nxt.prdata = rd;
			nxt.pready = 1'b1;
			nxt.pslverr = !reg_mapped;
		end

		// Access phase: a write takes effect only on the edge that sees pready
		if (psel && penable && r.pready && pwrite && reg_mapped) begin
			m = bs_mask(r.img[dec_idx].bs);
			if (is_misc) begin
				nxt.hold = pwdata[MISC2_HOLD_BIT];
			end else if (is_regwin) begin
				nxt.reg_win = pwdata[31:REGWIN_LSB];
			end else if (dec_word == WORD_CTRL) begin
				nxt.img[dec_idx].en = pwdata[CTRL_EN_BIT];
				nxt.img[dec_idx].tc = pwdata[CTRL_TC_LSB +: 4];
				if (!r.ee_mode[dec_idx]) begin
					nxt.img[dec_idx].space = pwdata[CTRL_SPACE_BIT];
					nxt.img[dec_idx].bs = pwdata[CTRL_BS_LSB +: 4];
				end
			end else if (dec_word == WORD_LADDR) begin
				nxt.img[dec_idx].xlat = pwdata[LADDR_XLAT_LSB +: 16];
				if (!r.ee_mode[dec_idx]) begin
					nxt.img[dec_idx].base = pwdata[LADDR_BASE_LSB +: 16];
				end
			end else if (r.ee_mode[dec_idx]) begin
				// Only the compared bits hold a value, which gives BIOS its size probe
				nxt.img[dec_idx].base = pwdata[PBASE_BA_LSB +: 16] & m;
			end
		end

		// PCI side: address phase is the first frame-low cycle seen from idle
		case (r.state)
			ST_IDLE: begin
				if (!pci_in.frame_n) begin
					hit_sel = !img_hit[0];
					if (is_cfg0 || reg_hit || (img_hit != 2'b00)) begin
						nxt.state = ST_CLAIMED;
						nxt.resp.devsel_n = 1'b0;
						nxt.resp.drive_oe_n = 1'b0;
						nxt.resp.stop_n = !r.hold; // Retry while held
						// Config and register cycles stay inside the block
						nxt.pending = !r.hold && !is_cfg0 && !reg_hit;
						m = bs_mask(r.img[hit_sel].bs);
						nxt.req.image = hit_sel;
						nxt.req.write = is_write;
						nxt.req.io = is_io;
						nxt.req.addr = {(r.img[hit_sel].xlat & m) |
							(pci_in.ad[31:16] & ~m), pci_in.ad[15:0]};
						nxt.req.tc = r.img[hit_sel].tc;
					end else begin
						nxt.state = ST_IGNORED;
					end
				end
			end
			ST_CLAIMED: begin
				// Byte enables are valid one cycle after the command
				if (r.pending) begin
					nxt.pending = 1'b0;
					nxt.req.valid = 1'b1;
					nxt.req.byte_en = ~pci_in.cbe_n;
				end
				if (pci_in.frame_n) begin
					nxt.state = ST_IDLE;
					nxt.pending = 1'b0;
					nxt.resp.devsel_n = 1'b1;
					nxt.resp.stop_n = 1'b1;
					nxt.resp.drive_oe_n = 1'b1;
				end
			end
			ST_IGNORED: begin
				if (pci_in.frame_n) begin
					nxt.state = ST_IDLE;
				end
			end
			default: begin
				nxt.state = ST_IDLE;
			end
		endcase
	end

	// ==================================================================
	// The single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= ST_RESET;
		end else begin
			r <= nxt;
		end
	end

	// ==================================================================
	// Outputs straight from the state register
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign pci_resp = r.resp;
	assign local_req = r.req;

endmodule

/* pci_tgt_chk_props.sv */
// Concurrent checks on the PCI side of the target image decoder.
`timescale 1ns/10ps
module pci_tgt_chk
	import pci_tgt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire pci_addr_t pci_in,
	input wire pci_resp_t pci_resp,
	input wire local_req_t local_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==================================================================
	// Claim steps
	sequence s_held;
		!pci_resp.devsel_n && pci_in.frame_n;
	endsequence
	sequence s_claim;
		!pci_in.frame_n ##1 !pci_resp.devsel_n ##1 local_req.valid;
	endsequence

	// ==================================================================
	// Claim and translation checks
	claim_cause_a: assert property ($fell(pci_resp.devsel_n) |-> !$past(pci_in.frame_n))
		else $error("device select without address phase");
	sel_two_clk_a: assert property (local_req.valid |-> !$past(pci_resp.devsel_n)
		&& !$past(pci_in.frame_n, 2))
		else $error("device select late");
	sel_release_a: assert property (s_held |=> pci_resp.devsel_n)
		else $error("device select held after frame");
	retry_local_a: assert property (local_req.valid |-> $past(pci_resp.stop_n))
		else $error("local cycle on a retried access");
	retry_sel_a: assert property (!pci_resp.stop_n |-> !pci_resp.devsel_n)
		else $error("retry without device select");
	no_cfg_fwd_a: assert property (local_req.valid |-> $past(pci_in.cbe_n[3:1], 2) != 3'b101)
		else $error("config cycle forwarded");
	cmd_kind_a: assert property (local_req.valid |-> local_req.write == $past(pci_in.cbe_n[0], 2)
		&& local_req.io == ($past(pci_in.cbe_n[3:1], 2) == 3'b001))
		else $error("local cycle kind wrong");
	low_addr_a: assert property (local_req.valid |-> local_req.addr[15:0] == $past(pci_in.ad[15:0], 2))
		else $error("low address not passed");
	byte_lanes_a: assert property (local_req.valid |-> local_req.byte_en == ~$past(pci_in.cbe_n))
		else $error("byte enables wrong");
	oe_follow_a: assert property (pci_resp.drive_oe_n == pci_resp.devsel_n)
		else $error("response drive enable out of step");
	claim_seen_c: cover property (s_claim);
endmodule

bind pci_target_image_decoder pci_tgt_chk chk_u (.pclk(pclk), .presetn(presetn),
	.pci_in(pci_in), .pci_resp(pci_resp), .local_req(local_req));

/* pci_master_model.sv */
// Behavioural PCI bus master driving single data phase cycles.
`timescale 1ns/10ps
module pci_master_model
	import pci_tgt_pkg::*;
(
	input wire logic pclk,
	output pci_addr_t pci_in
);
	logic act_r = 1'b0;
	logic [7:0] cnt_r = 8'h00;
	pci_addr_t drv_r = '{1'b1, 1'b0, 32'h0000_0000, 4'hf};

	// Idle lines wander each cycle, so a stale address never looks valid
	always @(posedge pclk) cnt_r <= cnt_r + 8'h01;
	always_comb begin
		pci_in = drv_r;
		if (!act_r) begin
			pci_in.ad = {4{cnt_r}};
			pci_in.cbe_n = cnt_r[3:0];
		end
	end

	// Address phase, one data phase, then frame released to its pull-up level
	task automatic run(input logic [31:0] a, input logic [3:0] cmd, input logic sel,
		input logic [3:0] be_n);
		@(posedge pclk);
		act_r <= 1'b1;
		drv_r <= '{1'b0, sel, a, cmd};
		@(posedge pclk);
		drv_r.cbe_n <= be_n;
		drv_r.idsel <= 1'b0;
		drv_r.ad <= ~a;
		@(posedge pclk);
		drv_r.frame_n <= 1'b1;
		@(posedge pclk);
		act_r <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the PCI target image decoder.
`timescale 1ns/10ps
module tb_top
	import pci_tgt_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	pci_addr_t pci_in;
	pci_resp_t pci_resp;
	ee_cfg_t ee_cfg = {8'h00, 8'h80, 4'hf, 4'h0, 2'b10};
	logic hold_strap = 1'b1;
	local_req_t local_req;
	local_req_t cap;
	logic seen_dev = 1'b0;
	logic seen_stop = 1'b0;
	logic seen_req = 1'b0;
	int bad_count = 0;
	int num_checks = 0;

	always #10 pclk = ~pclk;
	pci_target_image_decoder dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pci_in(pci_in), .pci_resp(pci_resp),
		.ee_cfg(ee_cfg), .hold_strap(hold_strap), .local_req(local_req));
	pci_master_model master_u (.pclk(pclk), .pci_in(pci_in));

	// Record what the decoder answered during one frame
	always @(posedge pclk) begin
		if (pci_resp.devsel_n === 1'b0) seen_dev = 1'b1;
		if (pci_resp.stop_n === 1'b0) seen_stop = 1'b1;
		if (local_req.valid === 1'b1) begin
			cap = local_req;
			seen_req = 1'b1;
		end
	end

	// ==================================================================
	// Shared tasks
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Setup, then access held until pready; a hung slave ends the run
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [32:0] r);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		r = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			bad_count++;
			complete_run();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [32:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic rdk(input logic [11:0] a, input logic [32:0] exp, input string what);
		logic [32:0] r;
		apb(1'b0, a, 32'h0000_0000, r);
		chk(what, 64'(exp), 64'(r));
	endtask
	// Expected bits: device select, retry, local cycle
	task automatic frame(input logic [31:0] a, input logic [3:0] cmd, input logic sel,
		input logic [2:0] exp);
		seen_dev = 1'b0;
		seen_stop = 1'b0;
		seen_req = 1'b0;
		master_u.run(a, cmd, sel, 4'h3);
		chk("dev stop req", 64'(exp), 64'({seen_dev, seen_stop, seen_req}));
	endtask
	task automatic hit(input logic [31:0] a, input logic [3:0] cmd, input logic img,
		input logic io, input logic [31:0] la, input logic [3:0] tc);
		local_req_t e;
		e = '{1'b1, img, cmd[0], io, 4'hc, la, tc};
		frame(a, cmd, 1'b0, 3'b101);
		chk("local req", 64'(e), 64'(cap));
	endtask

	// ==================================================================
	// Scenarios
	// Power-up hold retries, clearing it admits Type 0 config only
	task automatic t_hold;
		rdk(OFS_MISC2, 33'h0_0000_0001, "hold");
		rdk(12'h0fc, 33'h1_0000_0000, "unmapped");
		frame(32'h0000_0800, CMD_CFG_RD, 1'b1, 3'b110);
		wr(OFS_MISC2, 32'h0000_0000);
		frame(32'h0000_0800, CMD_CFG_WR, 1'b1, 3'b100);
		frame(32'h0000_0801, CMD_CFG_RD, 1'b1, 3'b000);
	endtask
	// Image 0: 128 Mbyte memory image, every memory alias, upper range edge
	task automatic t_img0;
		logic [3:0] cmds [5];
		cmds = '{CMD_MEM_RD, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE, CMD_MEM_WR, CMD_MEM_WR_INV};
		wr(12'h000, 32'h80f5_0000);
		wr(12'h004, 32'h0800_5800);
		wr(12'h008, 32'hffff_ffff);
		rdk(12'h008, 33'h0_0000_0000, "base0 sizing");
		foreach (cmds[i]) hit(32'h0abc_1234, cmds[i], 1'b0, 1'b0, 32'h5abc_1234, 4'h5);
		hit(32'h0fff_fffc, CMD_MEM_RD, 1'b0, 1'b0, 32'h5fff_fffc, 4'h5);
		frame(32'h1000_0000, CMD_MEM_RD, 1'b0, 3'b000);
		frame(32'h0abc_1234, CMD_IO_RD, 1'b0, 3'b000);
	endtask
	// Image 1 set up from the EEPROM: read-only size, sizing, I/O space
	task automatic t_img1;
		wr(12'h010, 32'h8009_0000);
		rdk(12'h010, 33'h0_81f9_0000, "ctrl1");
		wr(12'h018, 32'hffff_ffff);
		rdk(12'h018, 33'h0_f800_0001, "size1");
		wr(12'h018, 32'h3000_0000);
		wr(12'h014, 32'h1234_7000);
		rdk(12'h014, 33'h0_3000_7000, "laddr1");
		hit(32'h3000_0010, CMD_IO_WR, 1'b1, 1'b1, 32'h7000_0010, 4'h9);
		frame(32'h3000_0010, CMD_MEM_RD, 1'b0, 3'b000);
	endtask
	// Both images off: former hits and a stray address go unclaimed, the register window is still claimed
	task automatic t_off;
		wr(12'h000, 32'h0075_0000);
		wr(12'h010, 32'h0009_0000);
		frame(32'h0abc_1234, CMD_MEM_RD, 1'b0, 3'b000);
		frame(32'h3000_0010, CMD_IO_RD, 1'b0, 3'b000);
		frame(32'h6000_0000, CMD_MEM_WR, 1'b0, 3'b000);
		frame(32'h0000_0100, CMD_MEM_RD, 1'b0, 3'b100);
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_hold();
		t_img0();
		t_img1();
		t_off();
		complete_run();
	end
endmodule
